// File: hw/uimt_pkg.sv
// shared constants and types of the user interrupt mask and timed channel block
package uimt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC = 24;
  localparam int unsigned NUM_TCH = 4;
  localparam int unsigned IV_W    = 16;
  localparam int unsigned ID_W    = 5;

  // ----------------------------------------------------------------
  // source bit layout of the selection mask
  // ----------------------------------------------------------------
  localparam int unsigned FAULT_BIT  = 0;
  localparam int unsigned EV_LO_LSB  = 1;
  localparam int unsigned CNT_LSB    = 5;
  localparam int unsigned EV_HI_LSB  = 11;
  localparam int unsigned TCH_LSB    = 15;
  localparam int unsigned PLG_LSB    = 19;
  localparam logic [23:0] MASK_RSVD  = 24'h000001;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_TSTART   = 12'h000;
  localparam logic [11:0] OFS_MDIS     = 12'h004;
  localparam logic [11:0] OFS_MEN      = 12'h008;
  localparam logic [11:0] OFS_MSTATE   = 12'h00C;
  localparam logic [11:0] OFS_TSTAT    = 12'h010;
  localparam logic [11:0] OFS_IV0      = 12'h020;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h030;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h034;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h038;
  localparam logic [11:0] OFS_SERVICE  = 12'h03C;

  // ----------------------------------------------------------------
  // fields of the timed-start word
  // ----------------------------------------------------------------
  localparam int unsigned TS_IV_LSB  = 0;
  localparam int unsigned TS_SEL_LSB = 16;
  localparam int unsigned TS_EN_BIT  = 31;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] MASK_RST   = 24'hFFFFFE;
  localparam logic [23:0] IRQ_EN_RST = 24'h000000;
  localparam logic [23:0] PEND_RST   = 24'h000000;

  // timed channel identifiers
  typedef enum logic [1:0] {
    timed_channel_id_0,
    timed_channel_id_1,
    timed_channel_id_2,
    timed_channel_id_3
  } uimt_tch_e;

endpackage

// File: hw/uimt_tmr_if.sv
// interface between the controller and one timed interrupt channel
`timescale 1ns/1ps
interface uimt_tmr_if #(parameter int unsigned IV_W = 16);
  logic            start;
  logic [IV_W-1:0] interval_ms;
  logic            enabled;
  logic            expire;
  logic [IV_W-1:0] cur_interval;
  logic [IV_W-1:0] elapsed;

  modport ctrl (output start, interval_ms, input enabled, expire, cur_interval, elapsed);
  modport chan (input start, interval_ms, output enabled, expire, cur_interval, elapsed);
endinterface

// File: hw/uimt_timed_ch.sv
// one timed interrupt channel with its own millisecond divider
`timescale 1ns/1ps
module uimt_timed_ch #(
  parameter int unsigned CLK_PER_MS = uimt_pkg::MS_CYCLES,
  parameter int unsigned IV_W       = uimt_pkg::IV_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control side
  uimt_tmr_if.chan tif
);
  localparam int unsigned PRE_W = (CLK_PER_MS > 1) ? $clog2(CLK_PER_MS) : 1;

  generate
    if (CLK_PER_MS < 2) begin : g_chk
      $error("CLK_PER_MS must be at least 2");
    end
  endgenerate

  logic [PRE_W-1:0] pre_reg;
  logic [IV_W-1:0]  iv_reg;
  logic [IV_W-1:0]  elapsed_reg;
  logic             en_reg;
  logic             expire_reg;
  logic             ms_tick;
  logic             reached;

  // one-cycle millisecond enable and interval compare
  assign ms_tick = (pre_reg == PRE_W'(CLK_PER_MS - 1));
  assign reached = (elapsed_reg == iv_reg - IV_W'(1));

  // divider, restarted with every start so the first period is a full one
  always_ff @(posedge clk)
  begin
    if (rst || tif.start || ms_tick || !en_reg)
      pre_reg <= '0;
    else
      pre_reg <= pre_reg + PRE_W'(1);
  end

  // interval, enabled flag and elapsed count
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      iv_reg      <= '0;
      en_reg      <= 1'b0;
      elapsed_reg <= '0;
      expire_reg  <= 1'b0;
    end
    else if (tif.start)
    begin
      iv_reg      <= tif.interval_ms;
      en_reg      <= (tif.interval_ms != '0);
      elapsed_reg <= '0;
      expire_reg  <= 1'b0;
    end
    else if (en_reg && ms_tick)
    begin
      expire_reg  <= reached;
      elapsed_reg <= reached ? '0 : elapsed_reg + IV_W'(1);
    end
    else
      expire_reg  <= 1'b0;
  end

  // outputs toward the controller
  assign tif.enabled      = en_reg;
  assign tif.expire       = expire_reg;
  assign tif.cur_interval = iv_reg;
  assign tif.elapsed      = elapsed_reg;
endmodule

// File: hw/uimt_prio.sv
// fixed priority picker, lowest bit index wins
`timescale 1ns/1ps
module uimt_prio #(
  parameter int unsigned N    = uimt_pkg::NUM_SRC,
  parameter int unsigned ID_W = uimt_pkg::ID_W
) (
  // requests
  input  wire logic [N-1:0]    req,
  // winner
  output logic                 found,
  output logic [ID_W-1:0]      id
);
  generate
    if (N > (1 << ID_W)) begin : g_chk
      $error("ID_W too narrow for N");
    end
  endgenerate

  // scan downward so the lowest set index is kept last
  always_comb
  begin
    found = 1'b0;
    id    = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        id    = ID_W'(i);
      end
    end
  end
endmodule

// File: hw/uimt_top.sv
// user interrupt mask, pending and timed channel controller with apb registers
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - timed start acts only when enable true
// - timed start status output equals enable
// - interval is 16-bit unsigned milliseconds
// - zero interval disables channel, clears flag
// - nonzero interval starts channel, sets flag
// - new interval applies at once, restarts count
// - interrupt only after full interval elapsed
// - program may start, stop, re-time at run
// - mask layout events, counters, timed, plug-ins
// - disable blocks selected sources only
// - enable re-allows selected sources, same layout
// - mask bit 0 reserved, fault unaffected
// - disable then enable bounds protected region
// - service highest to lowest priority order
module uimt_top #(
  parameter int unsigned CLK_PER_MS = uimt_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // interrupt sources, one-cycle pulses, bit layout of the mask
  input  wire logic [23:0] SRC_EVENT,
  // service request toward the program
  output logic             IRQ,
  output logic      [4:0]  IRQ_SRC_ID,
  // status of the last timed start
  output logic             TSTART_ENO
);

  // ----------------------------------------------------------------
  // register map, byte offsets, one word each
  // ----------------------------------------------------------------
  // 0x000 timed start: write [15:0] interval, [17:16] channel, [31] enable
  //       read bit 0 gives the status of the last timed start
  // 0x004 mask disable: write ones to block sources, bit 0 ignored
  // 0x008 mask enable: write ones to re-allow sources, bit 0 ignored
  // 0x00C mask state: read [23:0] allow bits, bit 0 always reads zero
  // 0x010 timed status: read [3:0] enabled flag of each channel
  // 0x020 channel words, 4 apart: [15:0] interval, [31:16] elapsed ms
  // 0x030 pending: read [23:0] sticky event bits
  // 0x034 pending clear: write ones to clear, a new event wins
  // 0x038 interrupt enable: read and write [23:0]
  // 0x03C service: read [5] request, [4:0] winning source
  // unmapped offsets answer with the error flag, writes are dropped
  // writes to read-only words are dropped without an error
  // reads are taken at the setup edge, so data is one cycle old
  // priority: lowest source index wins, fault source first
  // fault source is never masked, only its interrupt enable gates it
  // every access has exactly one access cycle, no wait states

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  generate
    if (CLK_PER_MS < 2)
    begin : g_chk_div
      $error("divider needs at least two clocks per millisecond");
    end
    if (uimt_pkg::NUM_TCH != 4)
    begin : g_chk_tch
      $error("channel select field serves exactly four channels");
    end
    if (uimt_pkg::NUM_SRC != 24)
    begin : g_chk_src
      $error("source ports and mask words are 24 bits wide");
    end
  endgenerate

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned NS  = uimt_pkg::NUM_SRC;
  localparam int unsigned NT  = uimt_pkg::NUM_TCH;
  localparam int unsigned IVW = uimt_pkg::IV_W;

  logic [NS-1:0]   allow_reg;
  logic [NS-1:0]   allow_next;
  logic [NS-1:0]   pend_reg;
  logic [NS-1:0]   pend_next;
  logic [NS-1:0]   irq_en_reg;
  logic            eno_reg;
  logic            irq_reg;
  logic [4:0]      irq_id_reg;
  logic [31:0]     prdata_reg;
  logic            pready_reg;
  logic            pslverr_reg;

  logic            setup;
  logic            wr;
  logic            hit_tstart;
  logic            hit_mdis;
  logic            hit_men;
  logic            hit_mstate;
  logic            hit_tstat;
  logic            hit_iv;
  logic            hit_istat;
  logic            hit_iclr;
  logic            hit_ien;
  logic            hit_serv;
  logic            mapped;
  logic [31:0]     rdata;
  logic [31:0]     rd_tstart;
  logic [31:0]     rd_mstate;
  logic [31:0]     rd_tstat;
  logic [31:0]     rd_istat;
  logic [31:0]     rd_ien;
  logic [31:0]     rd_serv;

  logic            ts_op;
  logic            ts_en;
  logic [1:0]      ts_sel;
  logic [IVW-1:0]  ts_iv;
  logic [NS-1:0]   wmask;
  logic [NS-1:0]   allow_eff;
  logic [NS-1:0]   events;
  logic [NS-1:0]   clr_bits;
  logic [NS-1:0]   serviceable;
  logic            pick_found;
  logic [4:0]      pick_id;

  logic [NT-1:0]   tch_enabled;
  logic [NT-1:0]   tch_expire;
  logic [31:0]     iv_word [NT];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------

  // phase qualifiers; writes land at the edge that completes access
  assign setup = PSEL && !PENABLE;
  assign wr    = PSEL && PENABLE && pready_reg && PWRITE;

  // register hits
  assign hit_tstart = (PADDR == uimt_pkg::OFS_TSTART);
  assign hit_mdis   = (PADDR == uimt_pkg::OFS_MDIS);
  assign hit_men    = (PADDR == uimt_pkg::OFS_MEN);
  assign hit_mstate = (PADDR == uimt_pkg::OFS_MSTATE);
  assign hit_tstat  = (PADDR == uimt_pkg::OFS_TSTAT);
  assign hit_iv     = (PADDR[11:4] == uimt_pkg::OFS_IV0[11:4])
                    && (PADDR[1:0] == 2'h0);
  assign hit_istat  = (PADDR == uimt_pkg::OFS_IRQ_STAT);
  assign hit_iclr   = (PADDR == uimt_pkg::OFS_IRQ_CLR);
  assign hit_ien    = (PADDR == uimt_pkg::OFS_IRQ_EN);
  assign hit_serv   = (PADDR == uimt_pkg::OFS_SERVICE);
  assign mapped     = hit_tstart | hit_mdis | hit_men | hit_mstate | hit_tstat
                    | hit_iv | hit_istat | hit_iclr | hit_ien | hit_serv;

  // read words of each register
  assign rd_tstart = {31'h00000000, eno_reg};
  assign rd_mstate = {8'h00, allow_reg};
  assign rd_tstat  = {28'h0000000, tch_enabled};
  assign rd_istat  = {8'h00, pend_reg};
  assign rd_ien    = {8'h00, irq_en_reg};
  assign rd_serv   = {26'h0000000, irq_reg, irq_id_reg};

  // read data select; write-only words read as zero
  assign rdata =
      hit_tstart ? rd_tstart :
      hit_mstate ? rd_mstate :
      hit_tstat  ? rd_tstat :
      hit_iv     ? iv_word[PADDR[3:2]] :
      hit_istat  ? rd_istat :
      hit_ien    ? rd_ien :
      hit_serv   ? rd_serv :
      32'h00000000;

  // bus answer: ready one cycle after setup, data sampled at setup
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg  <= (setup && !PWRITE) ? rdata : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // timed start operation
  // ----------------------------------------------------------------

  // fields of the written word
  assign ts_op  = wr && hit_tstart;
  assign ts_en  = PWDATA[uimt_pkg::TS_EN_BIT];
  assign ts_sel = PWDATA[uimt_pkg::TS_SEL_LSB +: 2];
  assign ts_iv  = PWDATA[uimt_pkg::TS_IV_LSB +: IVW];

  // status output mirrors the enable input of the last operation
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      eno_reg <= 1'b0;
    else if (ts_op)
      eno_reg <= ts_en;
  end

  // four channels, each started only when addressed and enabled
  // a start restarts the channel's divider and elapsed count, so a
  // re-time never fires early on the old interval's progress; the
  // first expiry comes a full interval after the landing edge, then
  // the pending bit one cycle later and the request one more
  generate
    for (genvar n = 0; n < NT; n++)
    begin : g_tch
      uimt_tmr_if #(.IV_W(IVW)) tif ();

      // start pulse for this channel at run time
      assign tif.start       = ts_op && ts_en
                             && (ts_sel == 2'(n));
      assign tif.interval_ms = ts_iv;
      assign tch_enabled[n]  = tif.enabled;
      assign tch_expire[n]   = tif.expire;
      assign iv_word[n]      = {tif.elapsed, tif.cur_interval};

      uimt_timed_ch #(
        .CLK_PER_MS (CLK_PER_MS),
        .IV_W       (IVW)
      ) u_ch (
        .clk (REF_CLK),
        .rst (SYS_RST),
        .tif (tif.chan)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // source mask
  // ----------------------------------------------------------------

  // reserved fault bit never reaches the mask storage
  assign wmask = PWDATA[NS-1:0] & ~uimt_pkg::MASK_RSVD;

  // disable clears selected bits, enable sets them, rest untouched
  assign allow_next =
      (wr && hit_mdis) ? (allow_reg & ~wmask) :
      (wr && hit_men)  ? (allow_reg | wmask)  :
      allow_reg;

  // fault source always allowed regardless of the mask
  assign allow_eff = allow_reg | uimt_pkg::MASK_RSVD;

  // mask storage
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      allow_reg <= uimt_pkg::MASK_RST;
    else
      allow_reg <= allow_next;
  end

  // ----------------------------------------------------------------
  // pending, clear and enable registers
  // ----------------------------------------------------------------

  // timed channel slots are fed by the channels, not the pins
  assign events = {SRC_EVENT[NS-1:uimt_pkg::PLG_LSB],
                   tch_expire,
                   SRC_EVENT[uimt_pkg::TCH_LSB-1:0]};

  // a new event wins over a clear in the same cycle
  assign clr_bits  = (wr && hit_iclr) ? PWDATA[NS-1:0] : '0;
  assign pend_next = (pend_reg & ~clr_bits) | events;

  // sticky pending bits
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      pend_reg <= uimt_pkg::PEND_RST;
    else
      pend_reg <= pend_next;
  end

  // interrupt enable register
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      irq_en_reg <= uimt_pkg::IRQ_EN_RST;
    else if (wr && hit_ien)
      irq_en_reg <= PWDATA[NS-1:0];
  end

  // ----------------------------------------------------------------
  // priority service
  // ----------------------------------------------------------------

  // blocked sources stay pending and are serviced once re-allowed
  // the mask gates service only, never latching, so a protected
  // region delays a source rather than losing it; the fault slot
  // ignores the mask but still needs its interrupt enable bit
  assign serviceable = pend_reg & irq_en_reg & allow_eff;

  uimt_prio #(
    .N    (NS),
    .ID_W (uimt_pkg::ID_W)
  ) u_prio (
    .req   (serviceable),
    .found (pick_found),
    .id    (pick_id)
  );

  // registered level request and winning source
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      irq_reg    <= 1'b0;
      irq_id_reg <= 5'h00;
    end
    else
    begin
      irq_reg    <= pick_found;
      irq_id_reg <= pick_id;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // every output straight from a flip-flop
  assign PRDATA     = prdata_reg;
  assign PREADY     = pready_reg;
  assign PSLVERR    = pslverr_reg;
  assign IRQ        = irq_reg;
  assign IRQ_SRC_ID = irq_id_reg;
  assign TSTART_ENO = eno_reg;

endmodule

// File: sim/uimt_top_asserts.sv
// port checker for the interrupt mask and timed channel block
`timescale 1ns/1ps
module uimt_top_asserts (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // apb slave
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // sources and service
  input wire logic [23:0] SRC_EVENT,
  input wire logic        IRQ,
  input wire logic [4:0]  IRQ_SRC_ID,
  input wire logic        TSTART_ENO
);
  // decoded bus phases
  wire logic setup_c = PSEL && !PENABLE;
  wire logic ts_wr   = PSEL && PENABLE && PREADY && PWRITE && (PADDR == uimt_pkg::OFS_TSTART);
  wire logic mapped  = PADDR inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h020,
                                     12'h024, 12'h028, 12'h02C, 12'h030, 12'h034, 12'h038,
                                     12'h03C};

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  chk_ready_setup:
    assert property (setup_c |=> PREADY) else $error("ready missing after setup");
  chk_ready_only:
    assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  chk_rdata_idle:
    assert property (!(PREADY && !PWRITE) |-> PRDATA == 32'h0) else $error("read data not zero");
  chk_err_decode:
    assert property (setup_c |=> PSLVERR == !$past(mapped)) else $error("error flag wrong");
  chk_eno_follow:
    assert property (ts_wr |=> TSTART_ENO == $past(PWDATA[31])) else $error("status not enable");
  chk_eno_hold:
    assert property (!ts_wr |=> $stable(TSTART_ENO)) else $error("status moved alone");
  chk_id_none:
    assert property (!IRQ |-> IRQ_SRC_ID == 5'h00) else $error("source id without request");
  chk_id_range:
    assert property (IRQ |-> IRQ_SRC_ID < 5'h18) else $error("source id out of range");
  chk_err_ready:
    assert property (PSLVERR |-> PREADY) else $error("error without ready");
  chk_tstart_read:
    assert property (setup_c && !PWRITE && (PADDR == uimt_pkg::OFS_TSTART)
                     |=> PRDATA == {31'h00000000, $past(TSTART_ENO)})
      else $error("start status read wrong");
endmodule

bind uimt_top uimt_top_asserts i_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_EVENT(SRC_EVENT), .IRQ(IRQ),
  .IRQ_SRC_ID(IRQ_SRC_ID), .TSTART_ENO(TSTART_ENO));

// File: sim/tb_top.sv
// self-checking bench for the interrupt mask and timed channel block
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned P = 4;
  logic        clk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        pen = 0;
  logic        pwr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] src = 24'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [4:0]  irq_id;
  logic        eno;
  int          n_fail = 0;
  int          checks_done = 0;

  uimt_top #(.CLK_PER_MS(P)) i_dut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_EVENT(src), .IRQ(irq), .IRQ_SRC_ID(irq_id), .TSTART_ENO(eno));

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the watchdog ends a hung transfer
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // let the landed write settle before callers look at outputs
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic pulse(input logic [23:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 24'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_decode;
    logic [31:0] q;
    logic        e;
    rd(uimt_pkg::OFS_MSTATE, q);
    chk(q, 32'h00FFFFFE);
    rd(uimt_pkg::OFS_IRQ_EN, q);
    chk(q, 32'h0);
    wr(uimt_pkg::OFS_MSTATE, 32'h0);
    rd(uimt_pkg::OFS_MSTATE, q);
    chk(q, 32'h00FFFFFE);
    apb(1'b0, 12'h040, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
  endtask

  task automatic t_mask;
    logic [31:0] q;
    wr(uimt_pkg::OFS_IRQ_EN, 32'h00FFFFFF);
    wr(uimt_pkg::OFS_MDIS, 32'h00000015);
    rd(uimt_pkg::OFS_MSTATE, q);
    chk(q, 32'h00FFFFEA);
    pulse(24'h00001C);
    chk({26'h0, irq, irq_id}, 32'h23);
    rd(uimt_pkg::OFS_IRQ_STAT, q);
    chk(q, 32'h0000001C);
    wr(uimt_pkg::OFS_IRQ_CLR, 32'h00000008);
    repeat (2) @(posedge clk);
    #1;
    chk({26'h0, irq, irq_id}, 32'h00);
    wr(uimt_pkg::OFS_MEN, 32'h00000014);
    repeat (2) @(posedge clk);
    #1;
    chk({26'h0, irq, irq_id}, 32'h22);
    wr(uimt_pkg::OFS_IRQ_CLR, 32'h00FFFFFF);
    pulse(24'h880001);
    chk({26'h0, irq, irq_id}, 32'h20);
    wr(uimt_pkg::OFS_IRQ_CLR, 32'h00000001);
    repeat (2) @(posedge clk);
    #1;
    chk({26'h0, irq, irq_id}, 32'h33);
    rd(uimt_pkg::OFS_SERVICE, q);
    chk(q, 32'h00000033);
    wr(uimt_pkg::OFS_IRQ_CLR, 32'h00FFFFFF);
  endtask

  task automatic t_timed_ops;
    logic [31:0] q;
    wr(uimt_pkg::OFS_IRQ_EN, 32'h0);
    wr(uimt_pkg::OFS_TSTART, 32'h00010005);
    chk({31'h0, eno}, 32'h0);
    rd(uimt_pkg::OFS_TSTAT, q);
    chk(q, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      wr(uimt_pkg::OFS_TSTART, 32'h80000001 | (c << 16));
      chk({31'h0, eno}, 32'h1);
    end
    rd(uimt_pkg::OFS_TSTAT, q);
    chk(q, 32'h0000000F);
    rd(uimt_pkg::OFS_TSTART, q);
    chk(q, 32'h00000001);
    wr(uimt_pkg::OFS_TSTART, 32'h8002FFFF);
    rd(12'h028, q);
    chk({16'h0, q[15:0]}, 32'h0000FFFF);
    wr(uimt_pkg::OFS_TSTART, 32'h00020005);
    chk({31'h0, eno}, 32'h0);
    rd(12'h028, q);
    chk({16'h0, q[15:0]}, 32'h0000FFFF);
    for (int c = 0; c < 4; c++)
      wr(uimt_pkg::OFS_TSTART, 32'h80000000 | (c << 16));
    rd(uimt_pkg::OFS_TSTAT, q);
    chk(q, 32'h0);
    wr(uimt_pkg::OFS_IRQ_CLR, 32'h00FFFFFF);
  endtask

  task automatic t_timed_irq;
    int n;
    wr(uimt_pkg::OFS_IRQ_EN, 32'h00010000);
    wr(uimt_pkg::OFS_TSTART, 32'h80010003);
    repeat (8) @(posedge clk);
    wr(uimt_pkg::OFS_TSTART, 32'h80010003);
    wait_irq(n);
    chk(32'(n >= 3 * P && n <= 3 * P + 4), 32'h1);
    #1;
    chk({26'h0, irq, irq_id}, 32'h30);
    wr(uimt_pkg::OFS_IRQ_CLR, 32'h00010000);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wait_irq(n);
    chk(32'(n >= 3 * P - 6 && n <= 3 * P - 4), 32'h1);
    wr(uimt_pkg::OFS_TSTART, 32'h80010000);
    wr(uimt_pkg::OFS_IRQ_CLR, 32'h00010000);
    repeat (40) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
  endtask

  // watchdog
  initial
  begin
    #100000;
    n_fail++;
    test_done;
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_decode;
    t_mask;
    t_timed_ops;
    t_timed_irq;
    test_done;
  end
endmodule
